// [rtl/dcd_bus_if.sv]
// two-wire open-drain bus joining the host end and the device end
`timescale 1ns/100ps
`default_nettype none
interface dcd_bus_if;
  logic scl;
  logic sda;
  logic sclHostOut;
  logic sclHostOe;
  logic sdaHostOut;
  logic sdaHostOe;
  logic sdaDevOut;
  logic sdaDevOe;

  // wired-and with pull-up: a line is low when any enabled driver pulls
  assign scl = !(sclHostOe && !sclHostOut);
  assign sda = !((sdaHostOe && !sdaHostOut) || (sdaDevOe && !sdaDevOut));

  modport host   (input scl, input sda, output sclHostOut, output sclHostOe,
                  output sdaHostOut, output sdaHostOe);
  modport device (input scl, input sda, output sdaDevOut, output sdaDevOe);
endinterface : dcd_bus_if
`default_nettype wire

// [rtl/dcd_device.sv]
// device end: serial command decoder for a 16-bit converter
// What this block does
// R01 - byte after address ack is control
// R02 - top bits set: no update, still ack
// R03 - load bits 00: temporary register only
// R04 - load bits 01: temporary and converter both
// R05 - load bits 10: converter from temporary register
// R06 - broadcast: select bit picks converter source
// R07 - broadcast ignores the two top bits
// R08 - master sends control bits three, one zero
// R09 - master sends select bit zero outside broadcast
// R10 - power-down flag: top three bits select mode
// R11 - power-down stored or applied per load bits
// R12 - broadcast select plus flag powers down
// R13 - first data byte is the upper half
// R14 - update on ack falling edge after lsb
// R15 - read address acked, then upper byte sent
// R16 - master ack gives lower, then control byte
// R17 - master nack ends read, line released
// R18 - read returns last received bytes
// R19 - further byte pairs repeat the update
// R20 - broadcast only for writes, pin ignored
// R21 - registers cleared at reset
`timescale 1ns/100ps
`default_nettype none
module dcd_device
  import dcd_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire logic  rst_b,
  dcd_bus_if.device  bus,
  input  wire logic  addressSelectPin,
  output logic [15:0] dacValue,
  output logic [15:0] tempValue,
  output logic        powerDownActive,
  output logic [2:0]  powerDownSel,
  output logic        updatePulse
);

  // ***************************************************************
  // helpers
  // ***************************************************************
  // address hit: own address either direction, broadcast write only
  function automatic logic addrHit(input logic [7:0] b, input logic pin);
    addrHit = (b[7:1] == {ADDR_BASE, pin, 1'b0}) ||
              (b == BCAST_ADDR);                                // R20
  endfunction : addrHit

  // read-back byte order: msb, lsb, control, then round again
  function automatic logic [1:0] nextTx(input logic [1:0] idx);
    case (idx)
      IDX_MSB: nextTx = IDX_LSB;
      IDX_LSB: nextTx = IDX_CTRL;                               // R16
      default: nextTx = IDX_MSB;
    endcase
  endfunction : nextTx

  // ***************************************************************
  // pin synchronisers and edge detection
  // ***************************************************************
  logic sclS;
  logic sdaS;
  logic pinS;
  logic sclD;
  logic sdaD;

  dcd_sync #(.W(3)) uSync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .din     ({bus.scl, bus.sda, addressSelectPin}),
    .dout    ({sclS, sdaS, pinS})
  );

  // a third stage gives the previous level for edge detection
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      sclD <= 1'b1;
      sdaD <= 1'b1;
    end
    else
    begin
      sclD <= sclS;
      sdaD <= sdaS;
    end
  end

  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  assign sclRise  = sclS && !sclD;
  assign sclFall  = !sclS && sclD;
  assign startDet = sclS && sclD && sdaD && !sdaS;
  assign stopDet  = sclS && sclD && !sdaD && sdaS;

  // ***************************************************************
  // bus engine
  // ***************************************************************
  dcd_dev_state_e state;
  logic [3:0] bitCnt;
  logic [7:0] shiftReg;
  logic [7:0] txShift;
  logic [1:0] byteIdx;
  logic [1:0] txIdx;
  logic       readMode;
  logic       acked;
  logic       pendUpdate;
  logic       applyUpdate;
  logic [7:0] ctrlByte;
  logic [7:0] msbByte;
  logic [7:0] lsbByte;
  logic [7:0] nextByte;

  // byte to send next in read-back, from the last received bytes
  always_comb
  begin
    case (txIdx)
      IDX_MSB: nextByte = msbByte;
      IDX_LSB: nextByte = lsbByte;
      default: nextByte = ctrlByte;
    endcase
  end

  // start and stop win over any state; sda only moves while scl is low
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state       <= DS_IDLE;
      bitCnt      <= 4'h0;
      shiftReg    <= 8'h00;
      txShift     <= 8'h00;
      byteIdx     <= IDX_ADDR;
      txIdx       <= IDX_MSB;
      readMode    <= 1'b0;
      acked       <= 1'b0;
      pendUpdate  <= 1'b0;
      applyUpdate <= 1'b0;
      bus.sdaDevOe <= 1'b0;
      ctrlByte    <= 8'h00;                                     // R21
      msbByte     <= 8'h00;
      lsbByte     <= 8'h00;
    end
    else
    begin
      applyUpdate <= 1'b0;
      if (stopDet)
      begin
        state        <= DS_IDLE;
        bus.sdaDevOe <= 1'b0;
      end
      else if (startDet)
      begin
        state        <= DS_RX;
        byteIdx      <= IDX_ADDR;
        bitCnt       <= 4'h0;
        bus.sdaDevOe <= 1'b0;
      end
      else
      begin
        case (state)
          DS_RX:
          begin
            if (sclRise && bitCnt != ACK_BIT)
            begin
              shiftReg <= {shiftReg[6:0], sdaS};
              bitCnt   <= bitCnt + 4'h1;
            end
            else if (sclFall && bitCnt == ACK_BIT)
            begin
              bitCnt       <= 4'h0;
              state        <= DS_ACK;
              bus.sdaDevOe <= 1'b1;   // every accepted byte is acked  R02
              case (byteIdx)
                IDX_ADDR:
                begin
                  if (addrHit(shiftReg, pinS))
                  begin
                    readMode <= shiftReg[0];                    // R15
                    byteIdx  <= IDX_CTRL;                       // R01
                  end
                  else
                  begin
                    state        <= DS_IDLE;
                    bus.sdaDevOe <= 1'b0;
                  end
                end
                IDX_CTRL:
                begin
                  ctrlByte <= shiftReg;                         // R01
                  byteIdx  <= IDX_MSB;
                end
                IDX_MSB:
                begin
                  msbByte <= shiftReg;                          // R18
                  byteIdx <= IDX_LSB;
                end
                default:
                begin
                  lsbByte    <= shiftReg;                       // R18
                  byteIdx    <= IDX_MSB;                        // R19
                  pendUpdate <= 1'b1;
                end
              endcase
            end
          end
          DS_ACK:
          begin
            if (sclFall)
            begin
              applyUpdate <= pendUpdate;                        // R14
              pendUpdate  <= 1'b0;
              if (readMode)
              begin
                txShift      <= msbByte;                        // R15
                txIdx        <= IDX_LSB;
                bus.sdaDevOe <= !msbByte[7];
                state        <= DS_TX;
              end
              else
              begin
                bus.sdaDevOe <= 1'b0;
                state        <= DS_RX;
              end
            end
          end
          DS_TX:
          begin
            if (sclFall)
            begin
              if (bitCnt == LAST_BIT)
              begin
                bus.sdaDevOe <= 1'b0;
                bitCnt       <= 4'h0;
                state        <= DS_TXACK;
              end
              else
              begin
                txShift      <= {txShift[6:0], 1'b0};
                bus.sdaDevOe <= !txShift[6];
                bitCnt       <= bitCnt + 4'h1;
              end
            end
          end
          DS_TXACK:
          begin
            if (sclRise)
              acked <= !sdaS;
            else if (sclFall)
            begin
              if (acked)
              begin
                txShift      <= nextByte;                       // R16
                bus.sdaDevOe <= !nextByte[7];
                txIdx        <= nextTx(txIdx);
                state        <= DS_TX;
              end
              else
                state <= DS_IDLE;   // line already released  R17
            end
          end
          default: state <= DS_IDLE;
        endcase
      end
    end
  end

  // open-drain: the data value is always low, only the enable moves
  always_ff @(posedge clk_sys)
  begin
    bus.sdaDevOut <= 1'b0;
  end

  // ***************************************************************
  // temporary and converter registers
  // ***************************************************************
  logic [15:0] rxWord;
  logic        tempPd;
  logic        topClear;
  logic        bcast;
  assign rxWord   = {msbByte, lsbByte};                         // R13
  assign topClear = !ctrlByte[CB_TOP_HI] && !ctrlByte[CB_TOP_LO];
  assign bcast    = ctrlByte[CB_LOAD_HI] && ctrlByte[CB_LOAD_LO];

  // the power-down flag travels with the data it qualifies
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      tempValue       <= 16'h0000;                              // R21
      tempPd          <= 1'b0;
      dacValue        <= 16'h0000;
      powerDownActive <= 1'b0;
      updatePulse     <= 1'b0;
    end
    else
    begin
      updatePulse <= 1'b0;
      if (applyUpdate && bcast)                                 // R07
      begin
        updatePulse <= 1'b1;
        if (ctrlByte[CB_BCAST_SEL])                             // R06
        begin
          dacValue        <= rxWord;
          powerDownActive <= ctrlByte[CB_PD_FLAG];              // R12
        end
        else
        begin
          dacValue        <= tempValue;
          powerDownActive <= tempPd;
        end
      end
      else if (applyUpdate && topClear)                         // R02
      begin
        case ({ctrlByte[CB_LOAD_HI], ctrlByte[CB_LOAD_LO]})
          2'h0:
          begin
            tempValue <= rxWord;                                // R03
            tempPd    <= ctrlByte[CB_PD_FLAG];                  // R11
          end
          2'h1:
          begin
            tempValue       <= rxWord;                          // R04
            tempPd          <= ctrlByte[CB_PD_FLAG];
            dacValue        <= rxWord;
            powerDownActive <= ctrlByte[CB_PD_FLAG];            // R11
            updatePulse     <= 1'b1;
          end
          default:
          begin
            dacValue        <= tempValue;                       // R05
            powerDownActive <= tempPd;
            updatePulse     <= 1'b1;
          end
        endcase
      end
    end
  end

  // mode select bits live in the upper data bits when flagged  R10
  assign powerDownSel = dacValue[PD_SEL_HI:PD_SEL_LO];

endmodule : dcd_device
`default_nettype wire

// [rtl/dcd_host.sv]
// host end: serial bus master that writes and reads back the decoder
`timescale 1ns/100ps
`default_nettype none
module dcd_host
  import dcd_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  dcd_bus_if.host          bus,
  input  wire logic        go,
  input  wire logic        readBack,
  input  wire logic        broadcast,
  input  wire logic        addressSelect,
  input  wire logic [7:0]  ctrlIn,
  input  wire logic [15:0] dataIn,
  output logic             busy,
  output logic             done,
  output logic             nackSeen,
  output logic [23:0]      rdData
);
  localparam int CW = (QUARTER > 1) ? $clog2(QUARTER) : 1;

  // ***************************************************************
  // quarter-bit enable divider
  // ***************************************************************
  logic [CW-1:0] divCnt;
  logic          tick;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b || !busy)
    begin
      divCnt <= '0;
      tick   <= 1'b0;
    end
    else
    begin
      tick   <= (divCnt == CW'(QUARTER - 1));
      divCnt <= (divCnt == CW'(QUARTER - 1)) ? '0 : divCnt + CW'(1);
    end
  end

  // ***************************************************************
  // sampled data line
  // ***************************************************************
  logic sdaS;
  dcd_sync #(.W(1)) uSync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .din     (bus.sda),
    .dout    (sdaS)
  );

  // ***************************************************************
  // byte sequencer
  // ***************************************************************
  dcd_host_state_e state;
  logic [1:0]  q;
  logic [3:0]  bitIdx;
  logic [1:0]  byteIdx;
  logic [7:0]  txShift;
  logic [7:0]  rxShift;
  logic        rdMode;
  logic [7:0]  ctrlReg;
  logic [15:0] dataReg;
  logic        txMode;
  logic [7:0]  addrByte;
  logic [7:0]  txNext;

  // broadcast reads are never issued
  assign txMode   = (byteIdx == IDX_ADDR) || !rdMode;
  assign addrByte = broadcast ? BCAST_ADDR
                              : {ADDR_BASE, addressSelect, 1'b0, readBack};

  always_comb
  begin
    case (byteIdx)
      IDX_ADDR: txNext = ctrlReg;
      IDX_CTRL: txNext = dataReg[15:8];
      default:  txNext = dataReg[7:0];
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state         <= HS_IDLE;
      q             <= 2'h0;
      bitIdx        <= 4'h0;
      byteIdx       <= IDX_ADDR;
      txShift       <= 8'h00;
      rxShift       <= 8'h00;
      rdMode        <= 1'b0;
      ctrlReg       <= 8'h00;
      dataReg       <= 16'h0000;
      busy          <= 1'b0;
      done          <= 1'b0;
      nackSeen      <= 1'b0;
      rdData        <= 24'h000000;
      bus.sclHostOe <= 1'b0;
      bus.sdaHostOe <= 1'b0;
    end
    else if (state == HS_IDLE)
    begin
      done <= 1'b0;
      if (go)
      begin
        ctrlReg <= ctrlIn;
        ctrlReg[CB_RSVD_HI] <= 1'b0;                            // R08
        ctrlReg[CB_RSVD_LO] <= 1'b0;                            // R08
        ctrlReg[CB_BCAST_SEL] <= ctrlIn[CB_BCAST_SEL] &&
          ctrlIn[CB_LOAD_HI] && ctrlIn[CB_LOAD_LO];             // R09
        dataReg  <= dataIn;
        rdMode   <= readBack && !broadcast;
        txShift  <= addrByte;
        nackSeen <= 1'b0;
        busy     <= 1'b1;
        q        <= 2'h0;
        state    <= HS_START;
      end
    end
    else if (tick)
    begin
      q <= q + 2'h1;
      case (state)
        HS_START:
        begin
          if (q == 2'h1)
            bus.sdaHostOe <= 1'b1;
          else if (q == 2'h2)
            bus.sclHostOe <= 1'b1;
          else if (q == 2'h3)
          begin
            state   <= HS_BIT;
            bitIdx  <= 4'h0;
            byteIdx <= IDX_ADDR;
          end
        end
        HS_BIT:
        begin
          case (q)
            2'h0:
            begin
              if (bitIdx != ACK_BIT)
                bus.sdaHostOe <= txMode && !txShift[7];
              else   // ack all but the last read byte  R17
                bus.sdaHostOe <= !txMode && (byteIdx != IDX_LSB);
            end
            2'h1: bus.sclHostOe <= 1'b0;
            2'h2:
            begin
              if (bitIdx != ACK_BIT)
                rxShift <= {rxShift[6:0], sdaS};
              else if (txMode && sdaS)
                nackSeen <= 1'b1;
            end
            default:
            begin
              bus.sclHostOe <= 1'b1;
              if (bitIdx != ACK_BIT)
              begin
                bitIdx  <= bitIdx + 4'h1;
                txShift <= {txShift[6:0], 1'b0};
              end
              else
              begin
                bitIdx <= 4'h0;
                if (!txMode)
                  rdData <= {rdData[15:0], rxShift};            // R16
                if (byteIdx == IDX_LSB || nackSeen)
                  state <= HS_STOP;
                else
                begin
                  byteIdx <= byteIdx + 2'h1;
                  txShift <= txNext;                            // R13
                end
              end
            end
          endcase
        end
        HS_STOP:
        begin
          if (q == 2'h0)
            bus.sdaHostOe <= 1'b1;
          else if (q == 2'h1)
            bus.sclHostOe <= 1'b0;
          else if (q == 2'h2)
            bus.sdaHostOe <= 1'b0;
          else
          begin
            state <= HS_IDLE;
            busy  <= 1'b0;
            done  <= 1'b1;
          end
        end
        default: state <= HS_IDLE;
      endcase
    end
  end

  // open-drain drivers only ever pull low
  always_ff @(posedge clk_sys)
  begin
    bus.sclHostOut <= 1'b0;
    bus.sdaHostOut <= 1'b0;
  end

endmodule : dcd_host
`default_nettype wire

// [rtl/dcd_pkg.sv]
// shared constants and state types for the command decoder link
package dcd_pkg;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_HZ         = 200_000_000;
  localparam int SCL_HZ         = 100_000;
  // four phases per serial bit; a least-time figure, so round up
  localparam int QUARTER_CYCLES = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);

  // ***************************************************************
  // addressing
  // ***************************************************************
  localparam logic [4:0] ADDR_BASE  = 5'h13;
  localparam logic [7:0] BCAST_ADDR = 8'h90;

  // ***************************************************************
  // control byte and data field positions
  // ***************************************************************
  localparam int CB_TOP_HI     = 7;
  localparam int CB_TOP_LO     = 6;
  localparam int CB_LOAD_HI    = 5;
  localparam int CB_LOAD_LO    = 4;
  localparam int CB_RSVD_HI    = 3;
  localparam int CB_BCAST_SEL  = 2;
  localparam int CB_RSVD_LO    = 1;
  localparam int CB_PD_FLAG    = 0;
  localparam int PD_SEL_HI     = 15;
  localparam int PD_SEL_LO     = 13;

  // ***************************************************************
  // byte sequencing
  // ***************************************************************
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT  = 4'h8;
  localparam logic [1:0] IDX_ADDR = 2'h0;
  localparam logic [1:0] IDX_CTRL = 2'h1;
  localparam logic [1:0] IDX_MSB  = 2'h2;
  localparam logic [1:0] IDX_LSB  = 2'h3;

  typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_ACK, DS_TX, DS_TXACK}
    dcd_dev_state_e;
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP}
    dcd_host_state_e;

endpackage : dcd_pkg

// [rtl/dcd_sync.sv]
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module dcd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;

  // ***************************************************************
  // meta stage feeds only the output stage
  // ***************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      meta <= '1;
      dout <= '1;   // idle bus level is high
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : dcd_sync
`default_nettype wire

// [tb/dac_command_decoder_test.sv]
// self-checking bench joining host and device ends over the serial link
`timescale 1ns/100ps
`default_nettype none
module dac_command_decoder_test;
  import dcd_pkg::*;
  // short quarters keep frames near 610 cycles each
  localparam int Q     = 4;
  localparam int LIMIT = 80000;
  localparam logic [7:0] CMDS [11] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h20,
    8'h30, 8'h34, 8'h35, 8'hf4, 8'h50, 8'h9a};
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        go = 1'b0;
  logic        readBack = 1'b0;
  logic        broadcast = 1'b0;
  logic        addressSelect = 1'b0;
  logic        addressSelectPin = 1'b0;
  logic [7:0]  ctrlIn = 8'h00;
  logic [15:0] dataIn = 16'h0000;
  logic        busy, done, nackSeen, powerDownActive, updatePulse;
  logic [23:0] rdData;
  logic [15:0] dacValue, tempValue, mTmp, mDac;
  logic [2:0]  powerDownSel;
  logic        mTmpPd, mPd;
  logic [15:0] lfsr = 16'h9f10;
  int          errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          pulses = 0;
  int          mPulses = 0;

  dcd_bus_if dcd_bus_if_i ();
  dcd_host #(.QUARTER(Q)) dcd_host_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .bus(dcd_bus_if_i), .go(go), .readBack(readBack),
    .broadcast(broadcast), .addressSelect(addressSelect), .ctrlIn(ctrlIn),
    .dataIn(dataIn), .busy(busy), .done(done), .nackSeen(nackSeen),
    .rdData(rdData));
  dcd_device dcd_device_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .bus(dcd_bus_if_i), .addressSelectPin(addressSelectPin),
    .dacValue(dacValue), .tempValue(tempValue),
    .powerDownActive(powerDownActive), .powerDownSel(powerDownSel),
    .updatePulse(updatePulse));
  dcd_link_monitor #(.QUARTER(Q)) dcd_link_monitor_i (.clk_sys(clk_sys),
    .rst_b(rst_b), .scl(dcd_bus_if_i.scl), .sda(dcd_bus_if_i.sda),
    .sclHostOut(dcd_bus_if_i.sclHostOut), .sclHostOe(dcd_bus_if_i.sclHostOe),
    .sdaHostOut(dcd_bus_if_i.sdaHostOut), .sdaHostOe(dcd_bus_if_i.sdaHostOe),
    .sdaDevOut(dcd_bus_if_i.sdaDevOut), .sdaDevOe(dcd_bus_if_i.sdaDevOe));

  // ***************************************************************
  // clock, hang guard and helpers
  // ***************************************************************
  always #2.5 clk_sys = ~clk_sys;

  // a stuck handshake would otherwise run forever
  always @(posedge clk_sys)
  begin
    cycles++;
    if (updatePulse === 1'b1)
      pulses++;   // one per converter load
    if (cycles == LIMIT)
    begin
      errors++;
      end_of_test();
    end
  end

  function automatic logic [15:0] nextRand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nextRand

  // the host clears bits 3 and 1, and the select bit outside broadcast
  function automatic logic [7:0] sanCtrl(input logic [7:0] c);
    logic [7:0] r;
    r = c & 8'hf5;
    if (!(c[5] && c[4]))
      r[2] = 1'b0;
    return r;
  endfunction : sanCtrl

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  // one host frame; done is looked at on the falling edge where it is settled
  task automatic xfer(input logic rd, input logic bc, input logic [7:0] c,
                      input logic [15:0] d);
    int n;
    @(posedge clk_sys);
    go <= 1'b1;
    readBack <= rd;
    broadcast <= bc;
    ctrlIn <= c;
    dataIn <= d;
    @(posedge clk_sys);
    go <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (done !== 1'b1 && n < 2000);
    check({23'h0, done}, 24'h1);
    check({23'h0, busy}, 24'h0);
  endtask : xfer

  // expected registers after one write, then compare and read back
  task automatic step(input logic [7:0] c);
    logic [7:0] s;
    logic [15:0] d;
    s = sanCtrl(c);
    lfsr = nextRand(lfsr);
    d = lfsr;
    xfer(1'b0, c[5] && c[4], c, d);
    if ((s[5] && s[4]) || s[7:6] == 2'b00)
      case (s[5:4])
        2'b00: {mTmp, mTmpPd} = {d, s[0]};
        2'b01: {mTmp, mTmpPd, mDac, mPd} = {d, s[0], d, s[0]};
        2'b10: {mDac, mPd} = {mTmp, mTmpPd};
        default: {mDac, mPd} = s[2] ? {d, s[0]} : {mTmp, mTmpPd};
      endcase
    // every converter load, same value or not, shows one pulse
    if (s[5:4] != 2'b00 && ((s[5] && s[4]) || s[7:6] == 2'b00))
      mPulses++;
    check({23'h0, nackSeen}, 24'h0);
    check({8'h00, dacValue}, {8'h00, mDac});
    check({8'h00, tempValue}, {8'h00, mTmp});
    check({23'h0, powerDownActive}, {23'h0, mPd});
    check({21'h0, powerDownSel}, {21'h0, mDac[15:13]});
    check(24'(pulses), 24'(mPulses));
    xfer(1'b1, 1'b0, 8'h00, 16'h0000);
    check(rdData, {d, s});
  endtask : step

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial
  begin
    {mTmp, mDac, mTmpPd, mPd} = '0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check({8'h00, dacValue}, 24'h0);
    check({8'h00, tempValue}, 24'h0);
    for (int p = 0; p < 2; p++)
      for (int k = 0; k < 11; k++)
        step(CMDS[k]);
    // wrong select bit: no ack, converter untouched
    @(posedge clk_sys);
    addressSelect <= 1'b1;
    xfer(1'b0, 1'b0, 8'h10, 16'h1234);
    check({23'h0, nackSeen}, 24'h1);
    check({8'h00, dacValue}, {8'h00, mDac});
    check(24'(pulses), 24'(mPulses));
    // broadcast still answered with the pin flipped
    @(posedge clk_sys);
    addressSelectPin <= 1'b1;
    step(8'h34);
    step(8'h10);
    end_of_test();
  end
endmodule : dac_command_decoder_test
`default_nettype wire

// [tb/dcd_link_monitor.sv]
// concurrent checks on the serial wires between host and device ends
`timescale 1ns/100ps
`default_nettype none
module dcd_link_monitor #(
  parameter int QUARTER = 4
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda,
  input wire logic sclHostOut,
  input wire logic sclHostOe,
  input wire logic sdaHostOut,
  input wire logic sdaHostOe,
  input wire logic sdaDevOut,
  input wire logic sdaDevOe
);
  // ***************************************************************
  // run-length helpers
  // ***************************************************************
  // nine bits is the longest legal device drive: address ack then a zero msb
  localparam int HOLD_MAX = 9 * 4 * (QUARTER + 1) + 8;
  localparam int LOW_MAX  = 4 * (QUARTER + 1);
  int devHold;
  int sclLow;

  // cycles the device has pulled data low without a break
  always_ff @(posedge clk_sys)
  begin
    devHold <= (!rst_b || !sdaDevOe) ? 0 : devHold + 1;
  end

  // cycles the clock line has stayed low without a break
  always_ff @(posedge clk_sys)
  begin
    sclLow <= (!rst_b || scl) ? 0 : sclLow + 1;
  end

  default clocking dcdClk @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // ***************************************************************
  // wire rules
  // ***************************************************************
  a_dev_open_drain: assert property (sdaDevOe |-> !sdaDevOut)
    else $error("device drives data high");
  a_host_open_drain: assert property (!(sclHostOe && sclHostOut)
    && !(sdaHostOe && sdaHostOut))
    else $error("host drives a line high");
  a_dev_ack_edge: assert property ($rose(sdaDevOe) |-> !scl)
    else $error("device pulls data while clock high");
  a_dev_release_edge: assert property ($fell(sdaDevOe) |-> !scl)
    else $error("device releases data while clock high");
  a_dev_steady_high: assert property (scl && $past(scl)
    |-> $stable(sdaDevOe))
    else $error("device data changes in clock high phase");
  a_start_by_host: assert property (scl && $fell(sda) |-> sdaHostOe)
    else $error("start seen without host pulling data");
  a_stop_by_host: assert property (scl && $past(scl) && $rose(sda)
    |-> $past(sdaHostOe))
    else $error("stop seen without host releasing data");
  a_dev_hold_bounded: assert property (devHold <= HOLD_MAX)
    else $error("device holds data low too long");
  a_scl_low_bounded: assert property (sclLow <= LOW_MAX)
    else $error("clock held low too long");
  a_reset_release: assert property (disable iff (1'b0)
    !rst_b |=> !sdaDevOe && !sdaHostOe && !sclHostOe)
    else $error("line still pulled after reset");
endmodule : dcd_link_monitor
`default_nettype wire
